// file: hdl/tsi_switch.sv
`timescale 1ns/100ps
module tsi_switch #(
    parameter int SLOT_W = 10,
    parameter int LANES = 8,
    parameter int BYTE_W = 8,
    parameter int TONE_AW = 6
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [1:0] mode,
    input wire logic wide,
    input wire logic frame_sync,
    input wire logic bit_tick,
    input wire logic [LANES-1:0] serial_in_lines,
    input wire logic [LANES-1:0] alt_in_lines,
    input wire logic [BYTE_W-1:0] par_in,
    input wire logic [BYTE_W-1:0] par_in_hi,
    input wire logic host_req,
    input wire logic [1:0] host_sel,
    input wire logic [SLOT_W-1:0] host_addr,
    input wire logic [SLOT_W-1:0] host_wdata,
    output logic host_ack,
    output logic [LANES-1:0] serial_out_lines,
    output logic [LANES-1:0] alt_out_lines,
    output logic [BYTE_W-1:0] par_out,
    output logic [BYTE_W-1:0] par_out_hi
);

    // ****************************************************
    // Mode decode and bit timing
    // ****************************************************
    logic serial;
    logic byte_end;
    logic [2:0] bit_q, bit_d;

    assign serial = (mode == tsi_pkg::MODE_SERIAL);

    always_comb begin
        bit_d = bit_q;
        if (frame_sync) begin
            bit_d = tsi_pkg::BIT_ZERO;
        end else if (bit_tick && serial) begin
            bit_d = bit_q + 3'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            bit_q <= tsi_pkg::BIT_ZERO;
        end else begin
            bit_q <= bit_d;
        end
    end

    assign byte_end = serial && bit_tick && !frame_sync &&
                      (bit_q == tsi_pkg::LAST_BIT);

    // ****************************************************
    // Serial lanes
    // ****************************************************
    logic [BYTE_W-1:0] rx_lo [LANES];
    logic [BYTE_W-1:0] rx_hi [LANES];
    logic [BYTE_W-1:0] tx_lo_q [LANES];
    logic [BYTE_W-1:0] tx_hi_q [LANES];
    logic [BYTE_W-1:0] tx_lo_d [LANES];
    logic [BYTE_W-1:0] tx_hi_d [LANES];
    logic lane_tick;

    assign lane_tick = serial && bit_tick && !frame_sync;

    for (genvar i = 0; i < LANES; i++) begin : g_lane
        serdes_lane #(.W(BYTE_W)) u_lo (
            .mclk(mclk),
            .rst(rst),
            .bit_tick(lane_tick),
            .byte_end(byte_end),
            .rx_bit(serial_in_lines[i]),
            .tx_byte(tx_lo_q[i]),
            .rx_byte(rx_lo[i]),
            .tx_bit(serial_out_lines[i])
        );
        serdes_lane #(.W(BYTE_W)) u_hi (
            .mclk(mclk),
            .rst(rst),
            .bit_tick(lane_tick),
            .byte_end(byte_end),
            .rx_bit(alt_in_lines[i]),
            .tx_byte(tx_hi_q[i]),
            .rx_byte(rx_hi[i]),
            .tx_bit(alt_out_lines[i])
        );
    end

    // ****************************************************
    // Write side
    // ****************************************************
    logic [SLOT_W-1:0] wr_slot_q, wr_slot_d;
    logic wr_start_q, wr_start_d;
    logic wr_busy_q, wr_busy_d;
    logic sw_we;
    logic wr_flush;
    logic [2:0] wr_lane;
    logic [BYTE_W-1:0] sw_wlo, sw_whi;

    assign wr_lane = wr_slot_q[2:0];
    // A write burst running at frame sync finishes and wraps to slot zero
    assign wr_flush = serial && (wr_start_q || wr_busy_q);
    assign sw_we = serial ? wr_busy_q : (bit_tick && !frame_sync);
    assign sw_wlo = serial ? rx_lo[wr_lane] : par_in;
    assign sw_whi = !wide ? tsi_pkg::BYTE_ZERO :
                    (serial ? rx_hi[wr_lane] : par_in_hi);

    always_comb begin
        wr_start_d = byte_end;
        wr_busy_d = wr_start_q ||
                    (wr_busy_q && wr_lane != tsi_pkg::LAST_LANE);
        wr_slot_d = wr_slot_q;
        if (frame_sync && !wr_flush) begin
            wr_slot_d = tsi_pkg::SLOT_ZERO;
            wr_busy_d = 1'b0;
            wr_start_d = 1'b0;
        end else if (sw_we) begin
            wr_slot_d = tsi_pkg::next_slot(wr_slot_q, mode);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_slot_q <= tsi_pkg::SLOT_ZERO;
            wr_start_q <= 1'b0;
            wr_busy_q <= 1'b0;
        end else begin
            wr_slot_q <= wr_slot_d;
            wr_start_q <= wr_start_d;
            wr_busy_q <= wr_busy_d;
        end
    end

    // ****************************************************
    // Read sequencer
    // ****************************************************
    tsi_pkg::rd_state_type rd_state_q, rd_state_d;
    logic [SLOT_W-1:0] rd_slot_q, rd_slot_d;
    logic rd_issue;

    assign rd_issue = serial ? (rd_state_q == tsi_pkg::RD_BURST) :
                      (bit_tick && !frame_sync);

    always_comb begin
        rd_state_d = rd_state_q;
        rd_slot_d = rd_slot_q;
        if (rd_issue) begin
            rd_slot_d = tsi_pkg::next_slot(rd_slot_q, mode);
        end
        case (rd_state_q)
            tsi_pkg::RD_IDLE: begin
                if (serial && byte_end) begin
                    rd_state_d = tsi_pkg::RD_BURST;
                end
            end
            tsi_pkg::RD_BURST: begin
                if (rd_slot_q[2:0] == tsi_pkg::LAST_LANE) begin
                    rd_state_d = tsi_pkg::RD_IDLE;
                end
            end
            default: begin
                rd_state_d = tsi_pkg::RD_IDLE;
            end
        endcase
        if (frame_sync) begin
            rd_slot_d = tsi_pkg::SLOT_ZERO;
            rd_state_d = serial ? tsi_pkg::RD_BURST : tsi_pkg::RD_IDLE;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_state_q <= tsi_pkg::RD_IDLE;
            rd_slot_q <= tsi_pkg::SLOT_ZERO;
        end else begin
            rd_state_q <= rd_state_d;
            rd_slot_q <= rd_slot_d;
        end
    end

    // ****************************************************
    // Host table writes
    // ****************************************************
    logic host_ack_q, host_ack_d;
    logic host_wr;
    logic conn_we, tsel_we, tpat_we;

    assign host_wr = host_req && !host_ack_q && !rd_issue;
    assign conn_we = host_wr && host_sel == tsi_pkg::HOST_CONN;
    assign tsel_we = host_wr && host_sel == tsi_pkg::HOST_TSEL;
    assign tpat_we = host_wr && host_sel == tsi_pkg::HOST_TPAT;

    always_comb begin
        host_ack_d = host_wr;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            host_ack_q <= 1'b0;
        end else begin
            host_ack_q <= host_ack_d;
        end
    end

    assign host_ack = host_ack_q;

    // ****************************************************
    // Tables and storage
    // ****************************************************
    logic [SLOT_W-1:0] conn_data;
    logic [BYTE_W-1:0] tsel_data;
    logic [BYTE_W-1:0] tpat_data;
    logic [BYTE_W-1:0] sw_lo, sw_hi;

    slot_ram #(.AW(SLOT_W), .DW(SLOT_W)) u_conn (
        .mclk(mclk),
        .wr_en(conn_we),
        .wr_addr(host_addr),
        .wr_data(host_wdata),
        .rd_addr(rd_slot_q),
        .rd_data(conn_data)
    );

    slot_ram #(.AW(SLOT_W), .DW(BYTE_W)) u_tsel (
        .mclk(mclk),
        .wr_en(tsel_we),
        .wr_addr(host_addr),
        .wr_data(host_wdata[BYTE_W-1:0]),
        .rd_addr(rd_slot_q),
        .rd_data(tsel_data)
    );

    slot_ram #(.AW(TONE_AW), .DW(BYTE_W)) u_tpat (
        .mclk(mclk),
        .wr_en(tpat_we),
        .wr_addr(host_addr[TONE_AW-1:0]),
        .wr_data(host_wdata[BYTE_W-1:0]),
        .rd_addr(tsel_data[TONE_AW-1:0]),
        .rd_data(tpat_data)
    );

    slot_ram #(.AW(SLOT_W), .DW(BYTE_W)) u_sw_lo (
        .mclk(mclk),
        .wr_en(sw_we),
        .wr_addr(wr_slot_q),
        .wr_data(sw_wlo),
        .rd_addr(conn_data),
        .rd_data(sw_lo)
    );

    slot_ram #(.AW(SLOT_W), .DW(BYTE_W)) u_sw_hi (
        .mclk(mclk),
        .wr_en(sw_we),
        .wr_addr(wr_slot_q),
        .wr_data(sw_whi),
        .rd_addr(conn_data),
        .rd_data(sw_hi)
    );

    // ****************************************************
    // Read pipeline and output
    // ****************************************************
    logic v1_q, v1_d, v2_q, v2_d;
    logic [2:0] lane1_q, lane1_d, lane2_q, lane2_d;
    logic ten2_q, ten2_d;
    logic [BYTE_W-1:0] word_lo, word_hi;
    logic [BYTE_W-1:0] pout_q, pout_d, pouth_q, pouth_d;

    assign word_lo = ten2_q ? tpat_data : sw_lo;
    assign word_hi = (ten2_q || !wide) ? tsi_pkg::BYTE_ZERO : sw_hi;

    always_comb begin
        v1_d = rd_issue;
        lane1_d = rd_slot_q[2:0];
        v2_d = v1_q;
        lane2_d = lane1_q;
        ten2_d = tsel_data[tsi_pkg::TONE_EN_BIT];
        pout_d = pout_q;
        pouth_d = pouth_q;
        for (int i = 0; i < LANES; i++) begin
            tx_lo_d[i] = tx_lo_q[i];
            tx_hi_d[i] = tx_hi_q[i];
        end
        if (v2_q && serial) begin
            tx_lo_d[lane2_q] = word_lo;
            tx_hi_d[lane2_q] = word_hi;
        end
        if (v2_q && !serial) begin
            pout_d = word_lo;
            pouth_d = word_hi;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            v1_q <= 1'b0;
            v2_q <= 1'b0;
            lane1_q <= tsi_pkg::BIT_ZERO;
            lane2_q <= tsi_pkg::BIT_ZERO;
            ten2_q <= 1'b0;
            pout_q <= tsi_pkg::BYTE_ZERO;
            pouth_q <= tsi_pkg::BYTE_ZERO;
            for (int i = 0; i < LANES; i++) begin
                tx_lo_q[i] <= tsi_pkg::BYTE_ZERO;
                tx_hi_q[i] <= tsi_pkg::BYTE_ZERO;
            end
        end else begin
            v1_q <= v1_d;
            v2_q <= v2_d;
            lane1_q <= lane1_d;
            lane2_q <= lane2_d;
            ten2_q <= ten2_d;
            pout_q <= pout_d;
            pouth_q <= pouth_d;
            for (int i = 0; i < LANES; i++) begin
                tx_lo_q[i] <= tx_lo_d[i];
                tx_hi_q[i] <= tx_hi_d[i];
            end
        end
    end

    assign par_out = pout_q;
    assign par_out_hi = pouth_q;

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence issue_s;
        rd_issue;
    endsequence

    sequence result_s;
        ##2 v2_q;
    endsequence

    host_ack_a: assert property (host_wr |=> host_ack_q)
        else $error("host write not acknowledged");

    host_clash_a: assert property (
        conn_we || tsel_we || tpat_we |-> !rd_issue)
        else $error("host write during slot read");

    wr_step_a: assert property (sw_we && !frame_sync |=>
        wr_slot_q == tsi_pkg::next_slot($past(wr_slot_q), $past(mode)))
        else $error("write counter did not step");

    frame_zero_a: assert property (frame_sync && !wr_flush |=>
        wr_slot_q == tsi_pkg::SLOT_ZERO && rd_slot_q == tsi_pkg::SLOT_ZERO)
        else $error("frame sync did not clear counters");

    rd_zero_a: assert property (frame_sync |=>
        rd_slot_q == tsi_pkg::SLOT_ZERO)
        else $error("frame sync did not clear read counter");

    wr_flush_a: assert property (frame_sync && wr_flush |->
        ##[1:9] wr_slot_q == tsi_pkg::SLOT_ZERO)
        else $error("write burst did not end the frame");

    read_pipe_a: assert property (issue_s |-> result_s)
        else $error("read pipeline lost a slot");

    burst_len_a: assert property (disable iff (rst || frame_sync)
        $rose(rd_state_q == tsi_pkg::RD_BURST) |->
        (rd_state_q == tsi_pkg::RD_BURST)[*8] ##1
        (rd_state_q == tsi_pkg::RD_IDLE))
        else $error("read burst not eight slots");

    wr_burst_a: assert property (disable iff (rst || frame_sync)
        $rose(wr_busy_q) |-> wr_busy_q[*8] ##1 !wr_busy_q)
        else $error("write burst not eight slots");

    par_out_a: assert property (v2_q && !serial |=>
        par_out == $past(word_lo) && par_out_hi == $past(word_hi))
        else $error("parallel output mismatch");

    tone_out_a: assert property (v2_q && !serial && ten2_q |=>
        par_out == $past(tpat_data) && par_out_hi == tsi_pkg::BYTE_ZERO)
        else $error("tone not driven on slot");

    lane_route_a: assert property (v2_q && serial |=>
        tx_lo_q[$past(lane2_q)] == $past(word_lo))
        else $error("switched word on wrong lane");

    wrap_512_a: assert property (mode == tsi_pkg::MODE_PAR512 &&
        sw_we && !frame_sync && wr_slot_q == tsi_pkg::LAST_SLOT_512 |=>
        wr_slot_q == tsi_pkg::SLOT_ZERO)
        else $error("512-slot frame did not wrap");

endmodule

// file: include/tsi_pkg.sv
// Notes on behaviour
// - Two 1K by 8-bit switch storage planes.
// - Connection table 1K by 10 bits.
// - 64x8 tone store, 1Kx8 tone selection.
// - Tone byte replaces switched data per slot.
// - Up to 1024 slots, 8 or 16 bits.
// - Mode 0: eight serial 128-channel lines.
// - Serial lines deserialised, multiplexed into storage.
// - Write counter stores slot at own number.
// - Connection table indexed by output slot.
// - Read counter, table entry, then storage read.
// - Serial mode reserialises words onto chosen lines.
// - Any input line slot to any output.
// - Mode 1: parallel 512 slots each way.
// - Mode 2: parallel 1024 slots each way.
// - Host writes connection and tone tables.
package tsi_pkg;

    // ****************************************************
    // Sizes and encodings
    // ****************************************************
    localparam int SLOT_W = 10;
    localparam int LANES = 8;
    localparam int BYTE_W = 8;
    localparam int TONE_AW = 6;
    localparam int TONE_EN_BIT = 7;
    localparam int LANE_W = 3;

    localparam logic [1:0] MODE_SERIAL = 2'h0;
    localparam logic [1:0] MODE_PAR512 = 2'h1;
    localparam logic [1:0] MODE_PAR1024 = 2'h2;

    localparam logic [1:0] HOST_CONN = 2'h0;
    localparam logic [1:0] HOST_TSEL = 2'h1;
    localparam logic [1:0] HOST_TPAT = 2'h2;

    localparam logic [9:0] SLOT_ZERO = 10'h000;
    localparam logic [9:0] SLOT_ONE = 10'h001;
    localparam logic [9:0] LAST_SLOT_512 = 10'h1ff;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] LAST_LANE = 3'h7;
    localparam logic [2:0] BIT_ZERO = 3'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_BURST = 2'b10
    } rd_state_type;

    // ****************************************************
    // Slot counter step, wraps per mode
    // ****************************************************
    function automatic logic [9:0] next_slot(input logic [9:0] s,
                                             input logic [1:0] m);
        logic [9:0] r;
        r = s + SLOT_ONE;
        if (m == MODE_PAR512 && s == LAST_SLOT_512) begin
            r = SLOT_ZERO;
        end
        return r;
    endfunction

endpackage

// file: hdl/slot_ram.sv
`timescale 1ns/100ps
module slot_ram #(
    parameter int AW = 10,
    parameter int DW = 8
) (
    input wire logic mclk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);

    // ****************************************************
    // Storage, registered read, old data on collision
    // ****************************************************
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule

// file: hdl/serdes_lane.sv
`timescale 1ns/100ps
module serdes_lane #(
    parameter int W = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic bit_tick,
    input wire logic byte_end,
    input wire logic rx_bit,
    input wire logic [W-1:0] tx_byte,
    output logic [W-1:0] rx_byte,
    output logic tx_bit
);

    // ****************************************************
    // Serial to parallel and back, MSB first
    // ****************************************************
    logic [W-1:0] sh_q, sh_d;
    logic [W-1:0] rxb_q, rxb_d;
    logic [W-1:0] tx_q, tx_d;

    always_comb begin
        sh_d = sh_q;
        rxb_d = rxb_q;
        tx_d = tx_q;
        if (bit_tick) begin
            if (byte_end) begin
                rxb_d = {sh_q[W-2:0], rx_bit};
                tx_d = tx_byte;
            end else begin
                sh_d = {sh_q[W-2:0], rx_bit};
                tx_d = {tx_q[W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sh_q <= '0;
            rxb_q <= '0;
            tx_q <= '0;
        end else begin
            sh_q <= sh_d;
            rxb_q <= rxb_d;
            tx_q <= tx_d;
        end
    end

    assign rx_byte = rxb_q;
    assign tx_bit = tx_q[W-1];

endmodule

// file: verif/line_model.sv
`timescale 1ns/100ps
// ****************************************
// Line side source for the switch
// ****************************************
module line_model (
    input wire logic mclk,
    input wire logic run,
    input wire logic [1:0] next_mode,
    input wire logic next_wide,
    output logic [1:0] mode,
    output logic wide,
    output logic frame_sync,
    output logic bit_tick,
    output logic [7:0] par_in,
    output logic [7:0] par_in_hi,
    output logic [7:0] serial_in_lines,
    output logic [7:0] alt_in_lines,
    output int tick_no,
    output int frame_no
);
    int phase = 0;
    int j;
    logic [15:0] w;

    function automatic logic [15:0] word_of(input logic [9:0] i);
        return {{i[9:8], i[5:0]} ^ 8'hc3, i[7:0] ^ 8'h5a};
    endfunction

    initial begin
        mode = 2'h2;
        wide = 1'b1;
        frame_sync = 1'b0;
        bit_tick = 1'b0;
        par_in = 8'h00;
        par_in_hi = 8'h00;
        serial_in_lines = 8'h00;
        alt_in_lines = 8'h00;
        tick_no = 0;
        frame_no = 0;
    end

    // Frame sync, then one tick every other cycle; data garbled between
    always @(negedge mclk) begin
        frame_sync <= 1'b0;
        bit_tick <= 1'b0;
        if (run && phase == 0) begin
            frame_sync <= 1'b1;
            mode <= next_mode;
            wide <= next_wide;
            frame_no <= frame_no + 1;
        end else if (run && phase[0]) begin
            j = (phase - 1) / 2;
            bit_tick <= 1'b1;
            tick_no <= j;
            w = word_of(j[9:0]);
            par_in <= w[7:0];
            par_in_hi <= w[15:8];
            for (int l = 0; l < 8; l++) begin
                w = word_of(10'(j / 8 * 8 + l));
                serial_in_lines[l] <= w[7 - j % 8];
                alt_in_lines[l] <= w[15 - j % 8];
            end
        end else begin
            par_in <= ~par_in;
            par_in_hi <= ~par_in_hi;
            serial_in_lines <= ~serial_in_lines;
            alt_in_lines <= ~alt_in_lines;
        end
        if (run) begin
            phase <= (phase == (mode == 2'h1 ? 1024 : 2048)) ? 0 : phase + 1;
        end
    end
endmodule

// file: verif/testbench.sv
`timescale 1ns/100ps
// ****************************************
// Switch testbench
// ****************************************
module testbench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic run = 1'b0;
    logic chk_on = 1'b0;
    logic next_wide = 1'b1;
    logic [1:0] next_mode = 2'h2;
    logic host_req = 1'b0;
    logic [1:0] host_sel = 2'h0;
    logic [9:0] host_addr = 10'h000;
    logic [9:0] host_wdata = 10'h000;
    logic host_ack, wide, frame_sync, bit_tick;
    logic [1:0] mode;
    logic [7:0] par_in, par_in_hi, serial_in_lines, alt_in_lines;
    logic [7:0] par_out, par_out_hi, serial_out_lines, alt_out_lines;
    logic [7:0] el, eh;
    logic [3:0] st_v = 4'h0;
    logic [9:0] st_s [0:3];
    logic [15:0] e;
    int tick_no, frame_no;
    int n_mismatch = 0;
    int cmp_count = 0;

    always #10 mclk = ~mclk;

    line_model u_line (.mclk(mclk), .run(run), .next_mode(next_mode),
        .next_wide(next_wide), .mode(mode), .wide(wide),
        .frame_sync(frame_sync), .bit_tick(bit_tick), .par_in(par_in),
        .par_in_hi(par_in_hi), .serial_in_lines(serial_in_lines),
        .alt_in_lines(alt_in_lines), .tick_no(tick_no),
        .frame_no(frame_no));

    tsi_switch DUT (.mclk(mclk), .rst(rst), .mode(mode), .wide(wide),
        .frame_sync(frame_sync), .bit_tick(bit_tick),
        .serial_in_lines(serial_in_lines), .alt_in_lines(alt_in_lines),
        .par_in(par_in), .par_in_hi(par_in_hi), .host_req(host_req),
        .host_sel(host_sel), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_ack(host_ack),
        .serial_out_lines(serial_out_lines),
        .alt_out_lines(alt_out_lines), .par_out(par_out),
        .par_out_hi(par_out_hi));

    function automatic logic [7:0] tsel_of(input logic [9:0] s);
        return (s[3:0] == 4'h9) ? {2'b10, s[9:4]} : 8'h40;
    endfunction

    function automatic logic [7:0] tpat_of(input logic [5:0] i);
        return {i, 2'b01} ^ 8'h96;
    endfunction

    function automatic logic [15:0] exp_word(input logic [9:0] s,
                                             input logic w);
        logic [9:0] c;
        c = s ^ 10'h0b5;
        if (s[3:0] == 4'h9) begin
            return {8'h00, tpat_of(s[9:4])};
        end
        return {w ? ({c[9:8], c[5:0]} ^ 8'hc3) : 8'h00, c[7:0] ^ 8'h5a};
    endfunction

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ****************************************
    // Output monitor
    // ****************************************
    always @(posedge mclk) begin
        st_v <= {st_v[2:0], bit_tick & chk_on & (mode != 2'h0)};
        st_s <= '{tick_no[9:0], st_s[0], st_s[1], st_s[2]};
        if (st_v[3]) begin
            e = exp_word(st_s[3], wide);
            check("par_out", par_out, e[7:0]);
            check("par_out_hi", par_out_hi, e[15:8]);
        end
        if (bit_tick & chk_on & (mode == 2'h0) & (tick_no >= 8)) begin
            for (int l = 0; l < 8; l++) begin
                e = exp_word(10'((tick_no / 8 - 1) * 8 + l), wide);
                el[l] = e[7 - tick_no % 8];
                eh[l] = e[15 - tick_no % 8];
            end
            check("serial_out", serial_out_lines, el);
            check("alt_out", alt_out_lines, eh);
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic wait_frame;
        int f0;
        int i;
        f0 = frame_no;
        i = 0;
        while (frame_no == f0 && i < 5000) begin
            @(negedge mclk);
            i++;
        end
        if (i == 5000) begin
            n_mismatch++;
            end_sim();
        end
    endtask

    task automatic host_write(input logic [1:0] sel, input logic [9:0] a,
                              input logic [9:0] d);
        int n;
        @(negedge mclk);
        host_req = 1'b1;
        host_sel = sel;
        host_addr = a;
        host_wdata = d;
        n = 0;
        while (host_ack !== 1'b1 && n < 12) begin
            @(posedge mclk);
            n++;
        end
        check("host_ack", {15'h0000, n < 12}, 16'h0001);
        if (n == 12) begin
            end_sim();
        end
        @(negedge mclk);
        host_req = 1'b0;
    endtask

    task automatic program_tables;
        for (int i = 0; i < 1024; i++) begin
            host_write(2'h0, 10'(i), 10'(i) ^ 10'h0b5);
            host_write(2'h1, 10'(i), {2'h0, tsel_of(10'(i))});
        end
        for (int i = 0; i < 64; i++) begin
            host_write(2'h2, 10'(i), {2'h0, tpat_of(6'(i))});
        end
        host_write(2'h3, 10'h000, 10'h3ff);
    endtask

    task automatic check_mode(input logic [1:0] m, input logic w,
                              input int n_exp);
        int c0;
        next_mode = m;
        next_wide = w;
        wait_frame();
        wait_frame();
        chk_on = 1'b1;
        c0 = cmp_count;
        wait_frame();
        chk_on = 1'b0;
        repeat (6) @(negedge mclk);
        check("compares", 16'(cmp_count - c0), 16'(n_exp));
    endtask

    initial begin
        repeat (4) @(negedge mclk);
        rst <= 1'b0;
        run <= 1'b1;
        @(negedge mclk);
        check("reset_out", {par_out_hi, par_out}, 16'h0000);
        program_tables();
        check_mode(2'h2, 1'b1, 2048);
        check_mode(2'h1, 1'b0, 1024);
        check_mode(2'h0, 1'b1, 2032);
        check_mode(2'h3, 1'b1, 2048);
        end_sim();
    end
endmodule
